// [hw/sep_port.sv]
// Serial EEPROM port: bit sequencer, ready/busy status and a modelled cell array
`timescale 1ns/100ps
module sep_port
  import sep_pkg::*;
#(
  parameter int WRITE_TIME_CYC = WRITE_TIME_CYC_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Serial pins
  input wire logic CHIP_SELECT,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_IN_PIN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OUT_EN,
  // Status
  output logic WRITE_BUSY
);
  // Three-stage sync per pin
  logic [2:0] cs_sync, sk_sync, di_sync;
  logic cs_lvl, sk_lvl;
  logic [SELECT_LOW_MIN_CYC:0] cs_low_cnt;
  logic [31:0] busy_cnt;
  logic write_en, busy, status_show;
  logic [4:0] bit_cnt;
  logic [HDR_W-1:0] hdr_sr;
  logic [DATA_W-1:0] data_sr;
  logic [ADDR_W-1:0] rd_addr;
  logic dout;
  logic job_valid;
  sep_job_s job;
  sep_state_e state;
  logic [DATA_W-1:0] mem [WORDS];

  // Pin levels and edges after the synchronisers
  wire cs_agree = cs_sync[2] == cs_sync[1];
  wire sk_agree = sk_sync[2] == sk_sync[1];
  wire cs_rise = cs_agree && cs_sync[1] && !cs_lvl;
  wire cs_fall = cs_agree && !cs_sync[1] && cs_lvl;
  wire sk_rise = sk_agree && sk_sync[1] && !sk_lvl && cs_lvl;
  wire di_bit = di_sync[2];
  // Deselect lasted long enough to show status
  wire cs_low_ok = cs_low_cnt >= (SELECT_LOW_MIN_CYC + 1)'(SELECT_LOW_MIN_CYC);
  // Start bit counts only while the array is idle
  wire start_ok = di_bit && !busy;
  wire sep_hdr_s hdr_next = {hdr_sr[HDR_W-2:0], di_bit};
  wire hdr_last = (state == SEP_HEADER) && (bit_cnt == 5'(HDR_W - 1));
  wire rd_cmd = hdr_next.opcode == OP_READ;
  wire is_ext = hdr_next.opcode == OP_EXT;
  wire [1:0] ext_code = hdr_next.addr[ADDR_W-1 -: 2];
  wire wants_data = (hdr_next.opcode == OP_WRITE) || (is_ext && ext_code == EXT_WRALL);
  wire is_erase = (hdr_next.opcode == OP_ERASE) || (is_ext && ext_code == EXT_ERALL);
  wire [DATA_W-1:0] data_next = {data_sr[DATA_W-2:0], di_bit};
  wire data_last = bit_cnt == 5'(DATA_W - 1);
  wire busy_done = busy && (busy_cnt == 32'(WRITE_TIME_CYC - 1));

  // Shared output pin: read bits or ready/busy level
  assign SERIAL_DATA_OUT_EN = cs_lvl && ((state == SEP_READ_OUT) || status_show);
  assign SERIAL_DATA_OUT = (state == SEP_READ_OUT) ? dout : !busy;
  assign WRITE_BUSY = busy;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cs_sync <= 3'h0;
      sk_sync <= 3'h0;
      di_sync <= 3'h0;
      cs_lvl <= 1'b0;
      sk_lvl <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[1:0], CHIP_SELECT};
      sk_sync <= {sk_sync[1:0], SERIAL_CLOCK_PIN};
      di_sync <= {di_sync[1:0], SERIAL_DATA_IN_PIN};
      if (cs_agree) begin
        cs_lvl <= cs_sync[1];
      end
      if (sk_agree) begin
        sk_lvl <= sk_sync[1];
      end
    end
  end

  // Select-low interval timer, saturating
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cs_low_cnt <= '0;
    end else if (cs_lvl) begin
      cs_low_cnt <= '0;
    end else if (!cs_low_ok) begin
      cs_low_cnt <= cs_low_cnt + 1'b1;
    end
  end

  // Programming timer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy <= 1'b0;
      busy_cnt <= '0;
    end else if (busy_done) begin
      busy <= 1'b0;
      busy_cnt <= '0;
    end else if (busy) begin
      busy_cnt <= busy_cnt + 1'b1;
    end else if (cs_fall && job_valid) begin
      busy <= 1'b1;
    end
  end

  // Cell array update at end of programming
  always_ff @(posedge CLK) begin
    if (busy_done) begin
      for (int i = 0; i < WORDS; i++) begin
        if (job.all || job.addr == ADDR_W'(i)) begin
          mem[i] <= job.erase ? ERASED_WORD : job.data;
        end
      end
    end
  end

  // Bit sequencer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= SEP_IDLE;
      bit_cnt <= '0;
      hdr_sr <= '0;
      data_sr <= '0;
      rd_addr <= '0;
      dout <= 1'b0;
      write_en <= 1'b0;
      job_valid <= 1'b0;
      job <= '0;
      status_show <= 1'b0;
    end else if (!cs_lvl) begin
      state <= SEP_IDLE;
      bit_cnt <= '0;
      // Job handed to the timer on the fall; arm the status display
      if (job_valid) begin
        job_valid <= 1'b0;
        status_show <= 1'b1;
      end
      if (cs_rise && status_show && !cs_low_ok) begin
        status_show <= 1'b0; // deselect too short, no status
      end
    end else if (sk_rise) begin
      case (state)
        SEP_IDLE: begin
          if (start_ok) begin
            state <= SEP_HEADER;
            status_show <= 1'b0;
          end
        end
        SEP_HEADER: begin
          hdr_sr <= hdr_next;
          bit_cnt <= bit_cnt + 1'b1;
          // Command decode on the last address bit
          if (hdr_last) begin
            bit_cnt <= '0;
            state <= SEP_DONE;
            if (rd_cmd) begin
              state <= SEP_READ_OUT;
              rd_addr <= hdr_next.addr;
              data_sr <= mem[hdr_next.addr];
              dout <= 1'b0;
            end else if (is_ext && ext_code == EXT_ENABLE) begin
              write_en <= 1'b1;
            end else if (is_ext && ext_code == EXT_DISABLE) begin
              write_en <= 1'b0;
            end else if (wants_data) begin
              state <= SEP_DATA_IN;
            end else if (is_erase && write_en) begin
              job_valid <= 1'b1;
              job <= '{all: is_ext, erase: 1'b1, addr: hdr_next.addr, data: ERASED_WORD};
            end
          end
        end
        SEP_DATA_IN: begin
          data_sr <= data_next;
          bit_cnt <= bit_cnt + 1'b1;
          if (data_last) begin
            state <= SEP_DONE;
            if (write_en) begin
              job_valid <= 1'b1;
              job <= '{all: hdr_sr[HDR_W-1 -: 2] == OP_EXT, erase: 1'b0, addr: hdr_sr[ADDR_W-1:0],
                       data: data_next};
            end
          end
        end
        SEP_READ_OUT: begin
          dout <= data_sr[DATA_W-1];
          bit_cnt <= bit_cnt + 1'b1;
          if (data_last) begin
            bit_cnt <= '0;
            rd_addr <= rd_addr + 1'b1;
            data_sr <= mem[rd_addr + 1'b1];
          end else begin
            data_sr <= {data_sr[DATA_W-2:0], 1'b0};
          end
        end
        SEP_DONE: begin
          state <= SEP_DONE;
        end
        default: begin
          state <= SEP_IDLE;
        end
      endcase
    end
  end
endmodule

// [inc/sep_pkg.sv]
// Package for the serial EEPROM port block: timing counts, command layout and carrier types
package sep_pkg;
  // Clock and timing
  localparam int CLK_NS = 40;
  localparam int SELECT_LOW_MIN_NS = 200;
  localparam int SELECT_LOW_MIN_CYC = (SELECT_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_TIME_CYC_DEF = (WRITE_TIME_MS * 1000000) / CLK_NS;
  // Array geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int WORDS = 64;
  localparam int HDR_W = 2 + ADDR_W;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
  // Opcodes
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // Extended codes in the top two address bits
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRALL = 2'h1;
  localparam logic [1:0] EXT_ERALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;

  typedef enum logic [2:0] {
    SEP_IDLE, SEP_HEADER, SEP_DATA_IN, SEP_READ_OUT, SEP_ARMED, SEP_DONE
  } sep_state_e;

  typedef struct packed {
    logic [1:0] opcode;
    logic [ADDR_W-1:0] addr;
  } sep_hdr_s;

  // Pending programming job
  typedef struct packed {
    logic all;
    logic erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sep_job_s;
endpackage

// [tb/sep_port_checker.sv]
// Pin-level checker for the serial EEPROM port
`timescale 1ns/100ps
module sep_port_checker
  import sep_pkg::*;
#(parameter int WRITE_TIME_CYC = 300) (
  // Watched pins
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CHIP_SELECT,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_IN_PIN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OUT_EN,
  input wire logic WRITE_BUSY
);
  localparam int BMAX = WRITE_TIME_CYC + 9;
  logic [3:0] age;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Cycles since serial clock rise
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B) age <= 4'hf;
    else if ($rose(SERIAL_CLOCK_PIN)) age <= 4'h0;
    else if (age != 4'hf) age <= age + 4'h1;
  property p_hiz; !CHIP_SELECT [*5] |-> !SERIAL_DATA_OUT_EN; endproperty
  a_hiz: assert property (p_hiz) else $error("out not hiz");
  property p_sel; SERIAL_DATA_OUT_EN |-> $past(CHIP_SELECT, 3) || $past(CHIP_SELECT, 4); endproperty
  a_sel: assert property (p_sel) else $error("out while deselected");
  property p_bsy; WRITE_BUSY && SERIAL_DATA_OUT_EN |-> !SERIAL_DATA_OUT; endproperty
  a_bsy: assert property (p_bsy) else $error("busy not low");
  property p_go; $rose(WRITE_BUSY) |-> !CHIP_SELECT; endproperty
  a_go: assert property (p_go) else $error("write began while selected");
  property p_end; $rose(WRITE_BUSY) |-> ##[1:BMAX] !WRITE_BUSY; endproperty
  a_end: assert property (p_end) else $error("write too long");
  property p_sts;
    !CHIP_SELECT [*6] ##1 (CHIP_SELECT && WRITE_BUSY) [*6] |-> SERIAL_DATA_OUT_EN && !SERIAL_DATA_OUT;
  endproperty
  a_sts: assert property (p_sts) else $error("no status");
  property p_hold; (CHIP_SELECT && SERIAL_DATA_OUT_EN && WRITE_BUSY) [*4] |=> SERIAL_DATA_OUT_EN; endproperty
  a_hold: assert property (p_hold) else $error("status dropped");
  property p_rd;
    $changed(SERIAL_DATA_OUT) && SERIAL_DATA_OUT_EN && $past(SERIAL_DATA_OUT_EN)
      && !(WRITE_BUSY || $past(WRITE_BUSY) || $past(WRITE_BUSY, 2)) |-> age inside {[1:7]};
  endproperty
  a_rd: assert property (p_rd) else $error("out moved off clock rise");
  c_rd: cover property (SERIAL_DATA_OUT_EN && age == 4'h4);
  c_bsy: cover property ($rose(WRITE_BUSY));
  c_rdy: cover property ($fell(WRITE_BUSY) ##1 SERIAL_DATA_OUT_EN);
endmodule
bind sep_port sep_port_checker #(.WRITE_TIME_CYC(WRITE_TIME_CYC)) i_sep_port_checker (.CLK, .RST_B,
  .CHIP_SELECT, .SERIAL_CLOCK_PIN, .SERIAL_DATA_IN_PIN, .SERIAL_DATA_OUT, .SERIAL_DATA_OUT_EN, .WRITE_BUSY);

// [tb/sep_host_model.sv]
// Host model driving select, serial clock and data in
`timescale 1ns/100ps
module sep_host_model (
  // Clock and returned data
  input wire logic clk,
  input wire logic do_line,
  // Driven pins
  output logic cs,
  output logic sk,
  output logic di
);
  initial begin
    cs = 1'b0;
    sk = 1'b0;
    di = 1'b0;
  end
  task automatic sel(input logic lvl, input int n);
    cs <= lvl;
    repeat (n) @(posedge clk);
  endtask
  // MSB first; reply bit taken just before each rise
  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      di <= tx[i];
      repeat (4) @(posedge clk);
      rx = {rx[30:0], do_line};
      sk <= 1'b1;
      repeat (4) @(posedge clk);
      sk <= 1'b0;
    end
    di <= ~tx[0];
  endtask
endmodule

// [tb/sep_port_bench.sv]
// Self-checking bench for the serial EEPROM port
`timescale 1ns/100ps
module sep_port_bench
  import sep_pkg::*;
;
  localparam int WT = 300;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs, sk, di, dout, den, busy, do_line;
  logic [31:0] rx;
  int err_total = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  // Released line floats high
  assign do_line = den ? dout : 1'b1;
  sep_host_model i_sep_host_model (.clk(clk), .do_line(do_line), .cs(cs), .sk(sk), .di(di));
  sep_port #(.WRITE_TIME_CYC(WT)) i_sep_port (.CLK(clk), .RST_B(rst_b), .CHIP_SELECT(cs),
    .SERIAL_CLOCK_PIN(sk), .SERIAL_DATA_IN_PIN(di), .SERIAL_DATA_OUT(dout),
    .SERIAL_DATA_OUT_EN(den), .WRITE_BUSY(busy));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_enable();
    i_sep_host_model.sel(1'b1, 2);
    i_sep_host_model.shift({1'b1, OP_EXT, EXT_ENABLE, 4'h0}, 9, rx);
    i_sep_host_model.sel(1'b0, 8);
    chk("idle", 32'h0, busy);
  endtask
  task automatic t_write(input logic [5:0] a, input logic [15:0] d);
    i_sep_host_model.sel(1'b1, 2);
    i_sep_host_model.shift({1'b1, OP_WRITE, a, d}, 25, rx);
    i_sep_host_model.sel(1'b1, 8);
    chk("busy early", 32'h0, busy);
    i_sep_host_model.sel(1'b0, 8);
    chk("busy", 32'h1, busy);
    i_sep_host_model.sel(1'b1, 8);
    chk("status", 32'h0, do_line);
    i_sep_host_model.shift(32'h7, 3, rx);
    chk("refused", 32'h0, rx);
    for (int i = 0; i < WT + 20 && busy !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("ready", 32'h1, do_line);
    i_sep_host_model.sel(1'b0, 8);
  endtask
  task automatic t_read(input logic [5:0] a, input logic [15:0] d);
    i_sep_host_model.sel(1'b1, 2);
    i_sep_host_model.shift({3'h0, 1'b1, OP_READ, a, 17'h0}, 29, rx);
    chk("read", {16'h0, d}, rx & 32'h1ffff);
    i_sep_host_model.sel(1'b0, 8);
    chk("hiz", 32'h0, den);
  endtask
  task automatic t_erase(input logic [5:0] a);
    i_sep_host_model.sel(1'b1, 2);
    i_sep_host_model.shift({1'b1, OP_ERASE, a}, 9, rx);
    i_sep_host_model.sel(1'b0, 8);
    chk("erase busy", 32'h1, busy);
    for (int i = 0; i < WT + 20 && busy !== 1'b0; i++) @(posedge clk);
    chk("erase done", 32'h0, busy);
  endtask
  task automatic t_locked(input logic [5:0] a);
    i_sep_host_model.sel(1'b1, 2);
    i_sep_host_model.shift({1'b1, OP_EXT, EXT_DISABLE, 4'h0}, 9, rx);
    i_sep_host_model.sel(1'b0, 8);
    i_sep_host_model.sel(1'b1, 2);
    i_sep_host_model.shift({1'b1, OP_WRITE, a, 16'h1234}, 25, rx);
    i_sep_host_model.sel(1'b0, 8);
    chk("locked", 32'h0, busy);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    t_enable();
    t_write(6'h3f, 16'ha55a);
    t_read(6'h3f, 16'ha55a);
    t_write(6'h00, 16'h8001);
    t_read(6'h00, 16'h8001);
    t_erase(6'h00);
    t_read(6'h00, ERASED_WORD);
    t_locked(6'h3f);
    t_read(6'h3f, 16'ha55a);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
